//--- hw/tick_timer_regs.svh
// Register map and field constants for the countdown wake timer.
// Assumes inclusion by bare name from files under hw/.
`ifndef TICK_TIMER_REGS_SVH
`define TICK_TIMER_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TICK_COUNT_VALUE     4'h0
`define OFS_TICK_RELOAD_VALUE    4'h4
`define OFS_TICK_CONTROL         4'h8
`define OFS_SOFTWARE_IRQ_TRIGGER 4'hC

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTL_UNIT_ENABLE_BIT      0
`define CTL_RELOAD_ON_ZERO_BIT   1
`define CTL_START_BIT            2
`define CTL_DEBUG_PAUSE_EN_BIT   3
`define CTL_SW_PAUSE_BIT         4
`define CTL_WIDTH                5
`define CTL_RESET                5'h00
`define COUNT_RESET              32'h0000_0000
`define RELOAD_RESET             32'h0000_0000
`define COUNT_ONE                32'h0000_0001
`define COUNT_ZERO               32'h0000_0000
`define SWI_WIDTH                4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Core clock 40 MHz; tick rate 32 kHz (clock cycles per tick).
`define CLOCK_HZ                 40000000
`define TICK_HZ                  32768
`define TICK_DIV_CYCLES          (`CLOCK_HZ / `TICK_HZ)
`define TICK_DIV_WIDTH           11

`endif

//--- hw/tick_timer_pkg.sv
// Types shared by the countdown wake timer files.
// Assumes the register header is available for inclusion.
package tick_timer_pkg;
    typedef logic [31:0] word_t;
    typedef logic [3:0]  reg_addr_t;
    typedef enum logic [1:0] {
        RUN_IDLE    = 2'b00,
        RUN_COUNT   = 2'b01
    } run_state_e;
endpackage

//--- hw/tick_divider.sv
// Divider producing a one-cycle enable once per 32 kHz tick.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "tick_timer_regs.svh"

module tick_divider (
    input  wire logic CLOCK,
    input  wire logic SYS_RST,
    output logic      tick_pulse
);
    logic [`TICK_DIV_WIDTH-1:0] div_reg;
    localparam logic [`TICK_DIV_WIDTH-1:0] DIV_LAST = `TICK_DIV_WIDTH'(`TICK_DIV_CYCLES - 1);

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            div_reg    <= '0;
            tick_pulse <= 1'b0;
        end else if (div_reg == DIV_LAST) begin
            div_reg    <= '0;
            tick_pulse <= 1'b1;
        end else begin
            div_reg    <= div_reg + `TICK_DIV_WIDTH'(1);
            tick_pulse <= 1'b0;
        end
    end
endmodule

//--- hw/os_tick_countdown_timer.sv
// Countdown wake timer: 32-bit down counter ticked at 32 kHz, with
// one-shot or continuous reload, firmware and debug pause.
// Assumes a simple synchronous register port: one-cycle write and
// read strobes with a 4-bit byte offset; read data is registered.
`timescale 1ns/1ps
`include "tick_timer_regs.svh"

module os_tick_countdown_timer
    import tick_timer_pkg::*;
(
    input  wire logic                    CLOCK,
    input  wire logic                    SYS_RST,
    input  wire tick_timer_pkg::reg_addr_t REG_ADDR,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    input  wire tick_timer_pkg::word_t   REG_WDATA,
    output tick_timer_pkg::word_t        REG_RDATA,
    input  wire logic                    DEBUG_FREEZE,
    input  wire logic                    LOW_POWER_REQ,
    output logic                         LOW_POWER_ACK,
    output logic                         COUNTDOWN_WAKE_IRQ,
    output logic [`SWI_WIDTH-1:0]        SOFTWARE_IRQ
);
    import tick_timer_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    word_t                 count_reg;
    word_t                 reload_reg;
    logic [`CTL_WIDTH-1:0] ctl_reg;
    run_state_e            run_reg;
    logic                  tick_pulse;

    logic wr_count;
    logic wr_reload;
    logic wr_ctl;
    logic wr_swi;
    logic unit_en;
    logic paused;
    logic step;
    logic hit_zero;
    logic start_req;
    logic stop_req;
    logic start_bit_in;

    assign wr_count  = REG_WR && (REG_ADDR == `OFS_TICK_COUNT_VALUE);
    assign wr_reload = REG_WR && (REG_ADDR == `OFS_TICK_RELOAD_VALUE);
    assign wr_ctl    = REG_WR && (REG_ADDR == `OFS_TICK_CONTROL);
    assign wr_swi    = REG_WR && (REG_ADDR == `OFS_SOFTWARE_IRQ_TRIGGER);
    assign unit_en   = ctl_reg[`CTL_UNIT_ENABLE_BIT];

    tick_divider u_tick (
        .CLOCK      (CLOCK),
        .SYS_RST    (SYS_RST),
        .tick_pulse (tick_pulse)
    );

    // ----------------------------------------------------------------
    // Step decision
    // ----------------------------------------------------------------
    // software pause, or debug freeze when the debug pause enable bit is set
    assign paused = ctl_reg[`CTL_SW_PAUSE_BIT]
                    || (ctl_reg[`CTL_DEBUG_PAUSE_EN_BIT] && DEBUG_FREEZE);
    assign step     = (run_reg == RUN_COUNT) && unit_en && tick_pulse && !paused
                      && (count_reg != `COUNT_ZERO);
    assign hit_zero = step && (count_reg == `COUNT_ONE);

    assign start_bit_in = REG_WDATA[`CTL_START_BIT];
    assign start_req = wr_ctl && start_bit_in && REG_WDATA[`CTL_UNIT_ENABLE_BIT]
                       && (reload_reg != `COUNT_ZERO);
    assign stop_req  = wr_ctl && (!start_bit_in || !REG_WDATA[`CTL_UNIT_ENABLE_BIT]);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Start bit is set by an accepted start; any other control write or a one-shot zero hit clears it.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctl_reg <= `CTL_RESET;
        end else if (wr_ctl) begin
            if (!REG_WDATA[`CTL_UNIT_ENABLE_BIT]) begin
                ctl_reg <= `CTL_RESET;
            end else begin
                ctl_reg <= REG_WDATA[`CTL_WIDTH-1:0];
                ctl_reg[`CTL_START_BIT] <= start_req;
            end
        end else if (hit_zero && !ctl_reg[`CTL_RELOAD_ON_ZERO_BIT]) begin
            ctl_reg[`CTL_START_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Run state
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            run_reg <= RUN_IDLE;
        end else begin
            unique case (run_reg)
                RUN_IDLE: begin
                    if (start_req) begin
                        run_reg <= RUN_COUNT;
                    end
                end
                RUN_COUNT: begin
                    if (stop_req) begin
                        run_reg <= RUN_IDLE;
                    end else if (hit_zero && !ctl_reg[`CTL_RELOAD_ON_ZERO_BIT]) begin
                        run_reg <= RUN_IDLE;
                    end
                end
                default: begin
                    run_reg <= RUN_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            count_reg <= `COUNT_RESET;
        end else if (start_req) begin
            count_reg <= reload_reg;
        end else if (stop_req) begin
            count_reg <= `COUNT_ZERO;
        end else if (wr_count) begin
            count_reg <= REG_WDATA;
        end else if (hit_zero && ctl_reg[`CTL_RELOAD_ON_ZERO_BIT]) begin
            count_reg <= reload_reg;
        end else if (step) begin
            count_reg <= count_reg - `COUNT_ONE;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            reload_reg <= `RELOAD_RESET;
        end else if (wr_ctl && !REG_WDATA[`CTL_UNIT_ENABLE_BIT]) begin
            reload_reg <= `RELOAD_RESET;
        end else if (wr_reload) begin
            reload_reg <= REG_WDATA;
        end
    end

    // ----------------------------------------------------------------
    // Events and power
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            COUNTDOWN_WAKE_IRQ <= 1'b0;
            SOFTWARE_IRQ       <= '0;
        end else begin
            COUNTDOWN_WAKE_IRQ <= hit_zero;
            SOFTWARE_IRQ       <= wr_swi ? REG_WDATA[`SWI_WIDTH-1:0] : '0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            LOW_POWER_ACK <= 1'b0;
        end else begin
            LOW_POWER_ACK <= LOW_POWER_REQ && (run_reg == RUN_IDLE) && !start_req;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // register decode
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `OFS_TICK_COUNT_VALUE:  REG_RDATA <= count_reg;
                `OFS_TICK_RELOAD_VALUE: REG_RDATA <= reload_reg;
                `OFS_TICK_CONTROL:      REG_RDATA <= {{(32-`CTL_WIDTH){1'b0}}, ctl_reg};
                default:                REG_RDATA <= '0;
            endcase
        end
    end
endmodule

//--- verification/tick_timer_assertions.sv
// Port checker for the countdown wake timer.
// Assumes binding onto the timer top module; one clock domain.
`timescale 1ns/1ps
module tick_timer_assertions
    import tick_timer_pkg::*;
(
    input wire logic                      CLOCK,
    input wire logic                      SYS_RST,
    input wire tick_timer_pkg::reg_addr_t REG_ADDR,
    input wire logic                      REG_WR,
    input wire logic                      REG_RD,
    input wire tick_timer_pkg::word_t     REG_WDATA,
    input wire tick_timer_pkg::word_t     REG_RDATA,
    input wire logic                      DEBUG_FREEZE,
    input wire logic                      LOW_POWER_REQ,
    input wire logic                      LOW_POWER_ACK,
    input wire logic                      COUNTDOWN_WAKE_IRQ,
    input wire logic [3:0]                SOFTWARE_IRQ
);
    import tick_timer_pkg::*;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // ----------------------------------------------------------------
    // Cycles since the last wake event, saturating
    // ----------------------------------------------------------------
    logic [11:0] gap_reg;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST)
            gap_reg <= 12'hFFF;
        else if (COUNTDOWN_WAKE_IRQ)
            gap_reg <= 12'h000;
        else if (gap_reg != 12'hFFF)
            gap_reg <= gap_reg + 12'h001;
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_swi_wr;
        REG_WR && REG_ADDR == 4'hC;
    endsequence
    property p_swi; s_swi_wr |=> SOFTWARE_IRQ == $past(REG_WDATA[3:0]); endproperty
    property p_swi_idle; !(REG_WR && REG_ADDR == 4'hC) |=> SOFTWARE_IRQ == 4'h0; endproperty
    property p_irq_one; COUNTDOWN_WAKE_IRQ |=> !COUNTDOWN_WAKE_IRQ; endproperty
    // Events ride on ticks, so two can never be closer than one tick
    property p_irq_gap; COUNTDOWN_WAKE_IRQ |-> gap_reg >= 12'h4C3; endproperty
    property p_ack; LOW_POWER_ACK |-> $past(LOW_POWER_REQ); endproperty
    property p_unmapped; REG_RD && !(REG_ADDR inside {4'h0, 4'h4, 4'h8}) |=> REG_RDATA == 32'h0; endproperty
    property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
    property p_ctl_rsvd; REG_RD && REG_ADDR == 4'h8 |=> REG_RDATA[31:5] == 27'h0; endproperty
    property p_rst;
        $past(SYS_RST) |-> !COUNTDOWN_WAKE_IRQ && !LOW_POWER_ACK && REG_RDATA == 32'h0 && SOFTWARE_IRQ == 4'h0;
    endproperty
    a_swi: assert property (p_swi) else $error("soft irq mismatch");
    a_swi_idle: assert property (p_swi_idle) else $error("stray soft irq");
    a_irq_one: assert property (p_irq_one) else $error("wake pulse too long");
    a_irq_gap: assert property (p_irq_gap) else $error("wake too soon");
    a_ack: assert property (p_ack) else $error("ack without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control spare bits set");
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

bind os_tick_countdown_timer tick_timer_assertions u_chk (.CLOCK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_RD,
    .REG_WDATA, .REG_RDATA, .DEBUG_FREEZE, .LOW_POWER_REQ, .LOW_POWER_ACK, .COUNTDOWN_WAKE_IRQ, .SOFTWARE_IRQ);

//--- verification/tb.sv
// Register-port bench for the countdown wake timer.
// Assumes a tick every 1220 clocks and registered read data.
`timescale 1ns/1ps
module tb;
    import tick_timer_pkg::*;
    localparam int TK = 1220;
    logic       CLOCK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, DEBUG_FREEZE = 0, LOW_POWER_REQ = 0;
    logic       LOW_POWER_ACK, COUNTDOWN_WAKE_IRQ;
    logic [3:0] SOFTWARE_IRQ;
    reg_addr_t  REG_ADDR = 4'h0;
    word_t      REG_WDATA = 32'h0, REG_RDATA;
    int         err_total = 0, checked = 0, cyc = 0, last_irq = 0, gap = 0, irqs = 0;
    os_tick_countdown_timer DUT (.CLOCK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
        .DEBUG_FREEZE, .LOW_POWER_REQ, .LOW_POWER_ACK, .COUNTDOWN_WAKE_IRQ, .SOFTWARE_IRQ);
    initial forever #12.5 CLOCK = ~CLOCK;
    // ----------------------------------------------------------------
    // Wake event spacing, measured in clocks
    // ----------------------------------------------------------------
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (COUNTDOWN_WAKE_IRQ === 1'b1) begin
            gap <= cyc - last_irq;
            last_irq <= cyc;
            irqs <= irqs + 1;
        end
    end
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task chk(input word_t got, input word_t exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input reg_addr_t a, input word_t d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask
    task rd(input reg_addr_t a, input word_t exp);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, exp);
    endtask
    // Bounded wait; reports whether a wake event came
    task wait_irq(input int lim, input logic want);
        int n0;
        n0 = irqs;
        repeat (lim) if (irqs == n0) @(posedge CLOCK);
        #1 chk(word_t'(irqs != n0), word_t'(want));
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        wr(4'h6, 32'hFFFF_FFFF);
        rd(4'h6, 32'h0);
        rd(4'h4, 32'h0);
        wr(4'h4, 32'h1234_5678);
        rd(4'h4, 32'h1234_5678);
        wr(4'h0, 32'h0000_00A5);
        rd(4'h0, 32'h0000_00A5);
        wr(4'hC, 32'h0000_000F);
        rd(4'hC, 32'h0);
        wr(4'h4, 32'h0);
        wr(4'h8, 32'h5);
        rd(4'h8, 32'h1);
        wait_irq(3 * TK, 1'b0);
        $display("test registers done");
        wr(4'h4, 32'h2);
        wr(4'h8, 32'h5);
        rd(4'h8, 32'h5);
        LOW_POWER_REQ <= 1'b1;
        repeat (3) @(posedge CLOCK);
        #1 chk(word_t'(LOW_POWER_ACK), 32'h0);
        wait_irq(3 * TK, 1'b1);
        rd(4'h8, 32'h1);
        rd(4'h0, 32'h0);
        chk(word_t'(LOW_POWER_ACK), 32'h1);
        LOW_POWER_REQ <= 1'b0;
        wait_irq(TK + 100, 1'b0);
        $display("test one-shot done");
        // Freeze input is ignored while its enable is clear
        DEBUG_FREEZE <= 1'b1;
        wr(4'h4, 32'h1);
        wr(4'h8, 32'h7);
        wait_irq(2 * TK, 1'b1);
        wr(4'h4, 32'h3);
        wait_irq(2 * TK, 1'b1);
        chk(word_t'(gap), 32'h4C4);
        wait_irq(4 * TK, 1'b1);
        chk(word_t'(gap), 32'hE4C);
        DEBUG_FREEZE <= 1'b0;
        $display("test continuous done");
        wr(4'h8, 32'hF);
        wait_irq(4 * TK, 1'b1);
        // Freeze spans exactly four ticks from mid-count
        repeat (TK + 10) @(posedge CLOCK);
        DEBUG_FREEZE <= 1'b1;
        repeat (4 * TK) @(posedge CLOCK);
        DEBUG_FREEZE <= 1'b0;
        wait_irq(3 * TK, 1'b1);
        chk(word_t'(gap), 32'h215C);
        wr(4'h8, 32'h17);
        rd(4'h0, 32'h3);
        wait_irq(3 * TK, 1'b0);
        rd(4'h0, 32'h3);
        $display("test pause done");
        wr(4'h8, 32'h7);
        wr(4'h0, 32'h1);
        wait_irq(TK + 10, 1'b1);
        wr(4'h8, 32'h3);
        rd(4'h0, 32'h0);
        wait_irq(2 * TK, 1'b0);
        wr(4'h8, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        $display("test stop done");
        tally_and_finish;
    end
endmodule
